// ---- sslp_regs.vh ----
// Purpose: Timing constants for the sleep-capable SRAM access controller
// Assumes: 50 MHz controller clock, 10 ns speed grade memory
// Notes:   Times kept in their own unit; cycle counts derived from them
`ifndef SSLP_REGS_VH
`define SSLP_REGS_VH

// ****************************************
// Clock
// ****************************************
`define SSLP_CLK_PERIOD_NS     20

// ****************************************
// Sleep sequencing times
// ****************************************
`define SSLP_WAKE_PULSE_MIN_NS 100
`define SSLP_SETTLE_MS         1
`define SSLP_DESELECT_LIM_US   100
`define SSLP_ACCESS_DELAY_US   300

// Least times round up; the deselect limit gets no cycle count
`define SSLP_WAKE_PULSE_CYC    ((`SSLP_WAKE_PULSE_MIN_NS + `SSLP_CLK_PERIOD_NS - 1) / `SSLP_CLK_PERIOD_NS)
`define SSLP_SETTLE_CYC        ((`SSLP_SETTLE_MS * 1000000 + `SSLP_CLK_PERIOD_NS - 1) / `SSLP_CLK_PERIOD_NS)
`define SSLP_ACCESS_CYC        ((`SSLP_ACCESS_DELAY_US * 1000 + `SSLP_CLK_PERIOD_NS - 1) / `SSLP_CLK_PERIOD_NS)

// ****************************************
// Write and read timing (10 ns grade)
// ****************************************
`define SSLP_STROBE_FLOAT_NS   5
`define SSLP_DATA_SETUP_NS     5
`define SSLP_BYTE_LANE_NS      7
// Strobe low pulse: float plus setup, rounded up, at least byte-lane time
`define SSLP_WR_PULSE_CYC      ((`SSLP_STROBE_FLOAT_NS + `SSLP_DATA_SETUP_NS + `SSLP_CLK_PERIOD_NS - 1) / `SSLP_CLK_PERIOD_NS)
// Read: address to data valid 10 ns, take two cycles for margin
`define SSLP_RD_CYC            2

`endif

// ---- sslp_cnt.v ----
// Purpose: Loadable down counter for interval timing
// Assumes: Same clock as the controller
// Notes:   done_o is high while the count is zero
`timescale 1ns/1ps

module sslp_cnt #(
  parameter W = 24
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_n_i,
  // Control
  input  wire         load_i,
  input  wire [W-1:0] value_i,
  // Status
  output wire         done_o
);

  reg [W-1:0] count;  // Remaining cycles

  // ****************************************
  // Counter
  // ****************************************
  // Load wins over decrement
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= {W{1'b0}};
    end else if (load_i) begin
      count <= value_i;
    end else if (count != {W{1'b0}}) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done_o = (count == {W{1'b0}});

endmodule

// ---- sslp_ctrl.v ----
// Purpose: Host controller for an asynchronous 256K x 16 SRAM with sleep input
// Assumes: 50 MHz clock; memory data bus resolved outside from enables
// Notes:   Requests refused (ready low) until access is allowed after wake
`timescale 1ns/1ps
`include "sslp_regs.vh"

// Contract
// - Hold sleep low at least 100 ns
// - Keep sleep low through settling interval
// - Deselect chip within 100 us after wake
// - No access until 300 us after wake
// - Write needs strobe, select, lane, awake
// - Strobe pulse covers float plus setup
// - Byte lane low long enough before end
// - Write strobe high during reads
// - Sleep high during every access
// - Each lane selects its own byte
module sslp_ctrl (
  // Clock and reset
  input  wire        CLK_I,
  input  wire        RST_N_I,
  // User request
  input  wire        REQ_VALID_I,
  input  wire        REQ_WRITE_I,
  input  wire [17:0] REQ_ADDR_I,
  input  wire [15:0] REQ_WDATA_I,
  input  wire [1:0]  REQ_LANE_I,
  output wire        REQ_READY_O,
  output reg         RD_VALID_O,
  output reg  [15:0] RD_DATA_O,
  // Sleep control
  input  wire        SLEEP_I,
  output wire        ASLEEP_O,
  // Memory pins
  output reg  [17:0] MEM_ADDR_O,
  output reg         CHIP_SELECT_N_O,
  output reg         OUTPUT_DRIVE_N_O,
  output reg         WRITE_STROBE_N_O,
  output reg         LOW_BYTE_LANE_N_O,
  output reg         UPPER_BYTE_LANE_N_O,
  output reg         SLEEP_REQUEST_N_O,
  input  wire [15:0] MEM_DQ_I,
  output reg  [15:0] MEM_DQ_O,
  output reg  [1:0]  MEM_DQ_OE_N_O
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_WAIT  = 3'h0;  // Post-wake hold, no access
  localparam [2:0] ST_IDLE  = 3'h1;  // Ready for requests
  localparam [2:0] ST_WR    = 3'h2;  // Strobe low
  localparam [2:0] ST_RD    = 3'h3;  // Output enabled
  localparam [2:0] ST_SLEEP = 3'h4;  // Sleep request low, settling
  localparam [2:0] ST_DEEP  = 3'h5;  // Settled, stays until wake
  localparam [2:0] ST_DONE  = 3'h6;  // One turn-around cycle
  localparam [2:0] ST_BOOT  = 3'h7;  // First cycle after reset, arms the hold

  localparam W = 24;  // Fits the 1 ms count of 50000

  // Interval counts at counter width
  localparam [W-1:0] SETTLE_CYC = `SSLP_SETTLE_CYC;    // Deep-sleep settling
  localparam [W-1:0] ACCESS_CYC = `SSLP_ACCESS_CYC;    // Hold after wake or reset
  localparam [W-1:0] WR_CYC     = `SSLP_WR_PULSE_CYC;  // Write strobe low
  localparam [W-1:0] RD_CYC     = `SSLP_RD_CYC;        // Read window

  reg  [2:0]   state;       // Current state
  reg  [2:0]   next_state;  // Next state
  reg          cnt_load;    // Counter load strobe
  reg  [W-1:0] cnt_value;   // Counter load value
  wire         cnt_done;    // Interval elapsed
  reg          sleep_s1;    // Sleep request sync stage 1
  reg          sleep_s2;    // Sleep request sync stage 2
  reg  [15:0]  dq_s1;       // Read data sync stage 1
  reg  [15:0]  dq_s2;       // Read data sync stage 2
  reg  [1:0]   lanes;       // Lanes of the current access
  reg          was_rd;      // Previous state was a read

  // Interval timer shared by the hold, sleep, write and read states
  sslp_cnt #(.W(W)) u_cnt (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .load_i  (cnt_load),
    .value_i (cnt_value),
    .done_o  (cnt_done)
  );

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Pins from outside the clock domain pass two flops first
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
      dq_s1    <= 16'h0000;
      dq_s2    <= 16'h0000;
    end else begin
      sleep_s1 <= SLEEP_I;
      sleep_s2 <= sleep_s1;
      dq_s1    <= MEM_DQ_I;
      dq_s2    <= dq_s1;
    end
  end

  // Accept only when idle and awake
  assign REQ_READY_O = (state == ST_IDLE) && !sleep_s2;
  assign ASLEEP_O    = (state == ST_DEEP);

  // ****************************************
  // Next state
  // ****************************************
  always @* begin
    next_state = state;
    cnt_load   = 1'b0;
    cnt_value  = {W{1'b0}};
    case (state)
      ST_WAIT: begin
        // Access held off after sleep release
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (sleep_s2) begin
          // Low pulse must cover both wake minimum and settling
          next_state = ST_SLEEP;
          cnt_load   = 1'b1;
          cnt_value  = SETTLE_CYC;
        end else if (REQ_VALID_I) begin
          next_state = REQ_WRITE_I ? ST_WR : ST_RD;
          cnt_load   = 1'b1;
          cnt_value  = REQ_WRITE_I ? WR_CYC : RD_CYC;
        end
      end
      ST_WR: begin
        // Strobe pulse long enough for float plus setup and lane time
        if (cnt_done) begin
          next_state = ST_DONE;
        end
      end
      ST_RD: begin
        if (cnt_done) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      ST_SLEEP: begin
        // Sleep kept low through the whole settling time
        if (cnt_done) begin
          next_state = ST_DEEP;
        end
      end
      ST_DEEP: begin
        // Wake only once the minimum low pulse is surely met
        if (!sleep_s2) begin
          next_state = ST_WAIT;
          cnt_load   = 1'b1;
          cnt_value  = ACCESS_CYC;
        end
      end
      ST_BOOT: begin
        // Counter resets to zero, so the hold is loaded here once
        next_state = ST_WAIT;
        cnt_load   = 1'b1;
        cnt_value  = ACCESS_CYC;
      end
      default: begin
        next_state = ST_BOOT;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset starts in the boot state so first access waits too
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Memory pins
  // ****************************************
  // Registered outputs avoid glitches on the asynchronous strobes
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MEM_ADDR_O          <= 18'h00000;
      CHIP_SELECT_N_O     <= 1'b1;
      OUTPUT_DRIVE_N_O    <= 1'b1;
      WRITE_STROBE_N_O    <= 1'b1;
      LOW_BYTE_LANE_N_O   <= 1'b1;
      UPPER_BYTE_LANE_N_O <= 1'b1;
      SLEEP_REQUEST_N_O   <= 1'b1;
      MEM_DQ_O            <= 16'h0000;
      MEM_DQ_OE_N_O       <= 2'h3;
      lanes               <= 2'h0;
    end else begin
      // Sleep pin low exactly in sleeping states
      SLEEP_REQUEST_N_O <= !(next_state == ST_SLEEP || next_state == ST_DEEP);
      case (next_state)
        ST_WR: begin
          if (state == ST_IDLE) begin
            // Address, data and lanes set with the strobe
            MEM_ADDR_O <= REQ_ADDR_I;
            MEM_DQ_O   <= REQ_WDATA_I;
            lanes      <= REQ_LANE_I;
            MEM_DQ_OE_N_O       <= ~REQ_LANE_I;
            LOW_BYTE_LANE_N_O   <= ~REQ_LANE_I[0];
            UPPER_BYTE_LANE_N_O <= ~REQ_LANE_I[1];
          end
          CHIP_SELECT_N_O  <= 1'b0;
          OUTPUT_DRIVE_N_O <= 1'b1;
          WRITE_STROBE_N_O <= 1'b0;
        end
        ST_RD: begin
          if (state == ST_IDLE) begin
            MEM_ADDR_O          <= REQ_ADDR_I;
            lanes               <= REQ_LANE_I;
            LOW_BYTE_LANE_N_O   <= ~REQ_LANE_I[0];
            UPPER_BYTE_LANE_N_O <= ~REQ_LANE_I[1];
          end
          CHIP_SELECT_N_O  <= 1'b0;
          OUTPUT_DRIVE_N_O <= 1'b0;
          WRITE_STROBE_N_O <= 1'b1;
          MEM_DQ_OE_N_O    <= 2'h3;
        end
        default: begin
          // Strobe rises first and ends the write; chip deselected one cycle later
          CHIP_SELECT_N_O     <= (next_state == ST_DONE && state == ST_WR) ? 1'b0 : 1'b1;
          WRITE_STROBE_N_O    <= 1'b1;
          OUTPUT_DRIVE_N_O    <= 1'b1;
          LOW_BYTE_LANE_N_O   <= 1'b1;
          UPPER_BYTE_LANE_N_O <= 1'b1;
          // Data held one cycle past strobe rise, then released
          MEM_DQ_OE_N_O       <= (next_state == ST_DONE && state == ST_WR) ? MEM_DQ_OE_N_O : 2'h3;
        end
      endcase
    end
  end

  // ****************************************
  // Read data capture
  // ****************************************
  // Synchronised data sampled at the end of the turn-around cycle
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RD_VALID_O <= 1'b0;
      RD_DATA_O  <= 16'h0000;
      was_rd     <= 1'b0;
    end else begin
      RD_VALID_O <= 1'b0;
      // Output drive is already high in the turn-around cycle, so track the state
      was_rd     <= (state == ST_RD);
      if (state == ST_DONE && RD_VALID_O == 1'b0 && was_rd) begin
        RD_VALID_O <= 1'b1;
        // Unselected lane reads as zero
        RD_DATA_O  <= {lanes[1] ? dq_s2[15:8] : 8'h00, lanes[0] ? dq_s2[7:0] : 8'h00};
      end
    end
  end

endmodule

// ---- sslp_ctrl_sva.sv ----
// Purpose: Pin-order checks for the sleep-capable SRAM controller
// Assumes: 20 ns clock, so settling is 50000 cycles and the wake hold 15000
// Notes:   Counters track time since the sleep pin last moved
`timescale 1ns/1ps
module sslp_ctrl_sva (
  // Clock and reset
  input wire        CLK_I,
  input wire        RST_N_I,
  // Watched outputs
  input wire        REQ_READY_O,
  input wire        CHIP_SELECT_N_O,
  input wire        OUTPUT_DRIVE_N_O,
  input wire        WRITE_STROBE_N_O,
  input wire        LOW_BYTE_LANE_N_O,
  input wire        UPPER_BYTE_LANE_N_O,
  input wire        SLEEP_REQUEST_N_O,
  input wire [1:0]  MEM_DQ_OE_N_O
);
  localparam int SETTLE = 50000; // Sleep settling in cycles
  localparam int ACC = 15000;    // Wake hold in cycles
  int low_cnt;                   // Cycles with sleep pin low, saturating
  int wake_cnt;                  // Cycles since sleep pin high, saturating
  // ****************
  // Interval counters
  // ****************
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      low_cnt <= 0;
      wake_cnt <= 0;
    end else begin
      low_cnt <= SLEEP_REQUEST_N_O ? 0 : (low_cnt < SETTLE ? low_cnt + 1 : low_cnt);
      wake_cnt <= !SLEEP_REQUEST_N_O ? 0 : (wake_cnt < ACC ? wake_cnt + 1 : wake_cnt);
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_wake_pulse: assert property ($fell(SLEEP_REQUEST_N_O) |-> !SLEEP_REQUEST_N_O [*5])
    else $error("sleep pulse under 100 ns");
  a_settle_held: assert property ($rose(SLEEP_REQUEST_N_O) |-> low_cnt >= SETTLE)
    else $error("sleep released before settling");
  a_deselect_wake: assert property ($rose(SLEEP_REQUEST_N_O) |-> CHIP_SELECT_N_O)
    else $error("chip selected at wake");
  a_access_hold: assert property ($fell(CHIP_SELECT_N_O) |-> wake_cnt >= ACC)
    else $error("access inside wake hold");
  a_sleep_access: assert property (!CHIP_SELECT_N_O |-> SLEEP_REQUEST_N_O)
    else $error("access while sleep pin low");
  a_read_strobe: assert property (!OUTPUT_DRIVE_N_O |-> WRITE_STROBE_N_O)
    else $error("write strobe low in read");
  a_write_start: assert property ($fell(WRITE_STROBE_N_O) |->
    !CHIP_SELECT_N_O && SLEEP_REQUEST_N_O && !(LOW_BYTE_LANE_N_O && UPPER_BYTE_LANE_N_O))
    else $error("write started unqualified");
  a_write_pulse: assert property ($fell(WRITE_STROBE_N_O) |=> !WRITE_STROBE_N_O ##1 (WRITE_STROBE_N_O && !CHIP_SELECT_N_O) ##1 CHIP_SELECT_N_O)
    else $error("write pulse shape wrong");
  a_lane_drive: assert property ($fell(WRITE_STROBE_N_O) |-> MEM_DQ_OE_N_O == {UPPER_BYTE_LANE_N_O, LOW_BYTE_LANE_N_O})
    else $error("driven lanes differ from enables");
  a_ready_awake: assert property (REQ_READY_O |-> SLEEP_REQUEST_N_O && CHIP_SELECT_N_O)
    else $error("ready while busy or asleep");
  cover property ($fell(WRITE_STROBE_N_O));
  cover property ($fell(OUTPUT_DRIVE_N_O));
  cover property ($rose(SLEEP_REQUEST_N_O));
endmodule
bind sslp_ctrl sslp_ctrl_sva sslp_ctrl_sva_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REQ_READY_O(REQ_READY_O),
  .CHIP_SELECT_N_O(CHIP_SELECT_N_O), .OUTPUT_DRIVE_N_O(OUTPUT_DRIVE_N_O), .WRITE_STROBE_N_O(WRITE_STROBE_N_O),
  .LOW_BYTE_LANE_N_O(LOW_BYTE_LANE_N_O), .UPPER_BYTE_LANE_N_O(UPPER_BYTE_LANE_N_O),
  .SLEEP_REQUEST_N_O(SLEEP_REQUEST_N_O), .MEM_DQ_OE_N_O(MEM_DQ_OE_N_O));

// ---- sslp_sram_model.sv ----
// Purpose: Behavioural sleep-capable 256K x 16 SRAM
// Assumes: Read data lands LAT_NS after the address
// Notes:   Unwritten words read as the inverted address
`timescale 1ns/1ps
module sslp_sram_model #(
  parameter LAT_NS = 8,     // Slow read answer
  parameter SETTLE = 50000  // Sleep settling in cycles
) (
  // Clock, times settling only
  input  wire        clk_i,
  // Memory pins
  input  wire [17:0] addr_i,
  input  wire        chip_select_n_i,
  input  wire        output_drive_n_i,
  input  wire        write_strobe_n_i,
  input  wire [1:0]  lanes_n_i,
  input  wire        sleep_request_n_i,
  input  wire [15:0] dq_i,
  output wire [15:0] dq_o,
  output wire [1:0]  dq_drive_o,
  // Status
  output wire        deep_o
);
  reg [15:0] mem [0:262143]; // Storage
  reg [15:0] wdat;           // Data at write end
  reg [17:0] wadr;           // Address at write end
  reg [1:0]  wlane;          // Lanes open at write end
  integer    sleep_cnt = 0;  // Cycles held asleep
  // ****************
  // Access
  // ****************
  // Write is the overlap of all conditions; sleep blocks it
  wire wr_act = !write_strobe_n_i && !chip_select_n_i && sleep_request_n_i && lanes_n_i != 2'h3;
  wire rd_act = sleep_request_n_i && !chip_select_n_i && !output_drive_n_i && write_strobe_n_i;
  initial for (int i = 0; i < 262144; i++) mem[i] = ~i[15:0];
  always @* if (wr_act) begin
    wdat = dq_i;
    wadr = addr_i;
    wlane = ~lanes_n_i;
  end
  // First releasing edge ends the write, per lane
  always @(negedge wr_act) begin
    if (wlane[0]) mem[wadr][7:0] = wdat[7:0];
    if (wlane[1]) mem[wadr][15:8] = wdat[15:8];
  end
  // Lanes turn on and float at once; data follows the address LAT_NS later
  assign dq_drive_o = {2{rd_act}} & ~lanes_n_i;
  assign #(LAT_NS) dq_o = mem[addr_i];
  // Deep sleep once settling has run
  always @(posedge clk_i) sleep_cnt <= sleep_request_n_i ? 0 : sleep_cnt + 1;
  assign deep_o = sleep_cnt >= SETTLE;
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the sleep-capable SRAM controller
// Assumes: Header timing counts, 15000 cycle hold and 50000 cycle sleep
// Notes:   Reads are queued when taken and compared when answered
`timescale 1ns/1ps
module tb;
  localparam int ACC = 15000;
  localparam int SETTLE = 50000;
  logic clk = 0, rst_n = 0, valid = 0, wr = 0, slp = 0;
  logic [17:0] addr = '0;
  logic [15:0] wdat = '0, fpat = 16'h5A3C;
  logic [1:0] lane = 2'h1;
  wire ready, rd_valid, asleep, cs_n, oe_n, we_n, lb_n, ub_n, ds_n, deep;
  wire [15:0] rd_data, dq_c, dq_m, dq_bus;
  wire [17:0] maddr;
  wire [1:0] oe_c, drv_m;
  logic [15:0] shadow [int];
  logic [15:0] expq [$];
  int num_errors = 0, checks_done = 0;
  always #10 clk = ~clk;
  // Undriven lanes toggle so stale values cannot pass
  always @(posedge clk) fpat <= ~fpat;
  assign dq_bus[7:0] = !oe_c[0] ? dq_c[7:0] : drv_m[0] ? dq_m[7:0] : fpat[7:0];
  assign dq_bus[15:8] = !oe_c[1] ? dq_c[15:8] : drv_m[1] ? dq_m[15:8] : fpat[15:8];
  sslp_ctrl sslp_ctrl_i (.CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(valid), .REQ_WRITE_I(wr), .REQ_ADDR_I(addr),
    .REQ_WDATA_I(wdat), .REQ_LANE_I(lane), .REQ_READY_O(ready), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data),
    .SLEEP_I(slp), .ASLEEP_O(asleep), .MEM_ADDR_O(maddr), .CHIP_SELECT_N_O(cs_n), .OUTPUT_DRIVE_N_O(oe_n),
    .WRITE_STROBE_N_O(we_n), .LOW_BYTE_LANE_N_O(lb_n), .UPPER_BYTE_LANE_N_O(ub_n), .SLEEP_REQUEST_N_O(ds_n),
    .MEM_DQ_I(dq_bus), .MEM_DQ_O(dq_c), .MEM_DQ_OE_N_O(oe_c));
  sslp_sram_model sslp_sram_model_i (.clk_i(clk), .addr_i(maddr), .chip_select_n_i(cs_n), .output_drive_n_i(oe_n),
    .write_strobe_n_i(we_n), .lanes_n_i({ub_n, lb_n}), .sleep_request_n_i(ds_n), .dq_i(dq_bus), .dq_o(dq_m),
    .dq_drive_o(drv_m), .deep_o(deep));
  // ****************
  // Tasks
  // ****************
  task chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task tally_and_finish;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hold the request until taken, then note its outcome
  task req(input bit w, input [17:0] a, input [15:0] d, input [1:0] l);
    int n;
    logic [15:0] e;
    @(negedge clk);
    n = 0;
    valid = 1;
    wr = w;
    addr = a;
    wdat = d;
    lane = l;
    while (ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(n < 300, "request never taken");
    e = shadow.exists(a) ? shadow[a] : ~a[15:0];
    if (!w) expq.push_back(e & {{8{l[1]}}, {8{l[0]}}});
    else shadow[a] = {l[1] ? d[15:8] : e[15:8], l[0] ? d[7:0] : e[7:0]};
    @(negedge clk);
    valid = 0;
  endtask
  // Read answers compared against the oldest note
  always @(negedge clk) if (rd_valid === 1'b1) begin
    if (expq.size() == 0) chk(0, "unexpected read answer");
    else chk(rd_data === expq.pop_front(), "read data mismatch");
  end
  initial begin
    repeat (95000) @(negedge clk);
    chk(0, "timeout");
    tally_and_finish;
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    int n;
    void'($urandom(57819));
    repeat (10) @(negedge clk);
    rst_n = 1;
    repeat (100) @(negedge clk);
    chk(ready === 1'b0, "ready inside wake hold");
    for (n = 100; ready !== 1'b1 && n < ACC + 200; n++) @(negedge clk);
    chk(n >= ACC - 1 && n < ACC + 200, "hold after reset wrong");
    for (int i = 0; i < 24; i++) req($urandom % 2, 18'(32'h3FFFE + $urandom % 4), 16'($urandom), 2'(i % 3 + 1));
    slp = 1;
    repeat (4) @(negedge clk);
    valid = 1;
    for (n = 4; asleep !== 1'b1 && n < SETTLE + 200; n++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk(n >= SETTLE && deep === 1'b1, "sleep not settled");
    chk(ready === 1'b0 && ds_n === 1'b0 && cs_n === 1'b1, "request taken asleep");
    valid = 0;
    slp = 0;
    for (n = 0; ready !== 1'b1 && n < ACC + 200; n++) @(negedge clk);
    chk(n >= ACC && n < ACC + 200, "hold after wake wrong");
    for (int i = 0; i < 4; i++) req(0, 18'(32'h3FFFE + i), 16'h0000, 2'h3);
    repeat (10) @(negedge clk);
    chk(expq.size() == 0, "read answers missing");
    tally_and_finish;
  end
endmodule
